// *** core/inc_cfg.svh ***
// register offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and the register bank
`ifndef INC_CFG_SVH
`define INC_CFG_SVH
// register offsets
`define INC_ADDR_HB2_CTL 8'h1D
`define INC_ADDR_HB3_CTL 8'h1E
`define INC_ADDR_PART_ID 8'h1F
`define INC_ADDR_TW_B0 8'h30
`define INC_ADDR_TW_B1 8'h31
`define INC_ADDR_TW_B2 8'h32
`define INC_ADDR_TW_B3 8'h33
`define INC_ADDR_PH_LO 8'h34
`define INC_ADDR_PH_HI 8'h35
`define INC_ADDR_UPDATE 8'h36
`define INC_ADDR_IPH_LO 8'h38
`define INC_ADDR_IPH_HI 8'h39
`define INC_ADDR_IRQ_STAT 8'h20
`define INC_ADDR_IRQ_MASK 8'h21
// field positions
`define INC_SKIP_BIT 0
`define INC_MODE_MSB 6
`define INC_MODE_LSB 1
`define INC_LOAD_REQ_BIT 0
`define INC_LOAD_ACK_BIT 1
`define INC_MARK_REQ_BIT 4
`define INC_MARK_ACK_BIT 5
`define INC_IRQ_LOAD_BIT 0
`define INC_IRQ_MARK_BIT 1
// reset values and constants
`define INC_ZERO8 8'h00
`define INC_ZERO2 2'h0
`define INC_ZERO16 16'h0000
`define INC_ZERO32 32'h00000000
// identity value is arbitrary
`define INC_PART_ID 8'hA5
// marker high cycles that make an extended pulse
`define INC_EXT_MARK_CYC 3'h2
`endif

// *** core/inc_pkg.sv ***
// shared types of the interpolation and carrier configuration bank
// assumes: inc_cfg.svh is on the include path
package inc_pkg;
  `include "inc_cfg.svh"
  typedef logic [5:0] inc_hb_mode_t;
  typedef logic [7:0] inc_byte_t;
  typedef enum logic {INC_MARK_IDLE, INC_MARK_ARMED} inc_mark_state_t;
endpackage : inc_pkg

// *** core/inc_regs.sv ***
// register bank for halfband stages 2/3, carrier oscillator and I phase
// assumes: single sys_clk domain, plain strobe register port, async frame pin
`timescale 1ns/1ns
`include "inc_cfg.svh"

module inc_regs (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic frame_marker,
  output inc_pkg::inc_hb_mode_t second_halfband_mode,
  output logic skip_second_halfband,
  output logic second_modulate,
  output logic [2:0] second_band_pos,
  output inc_pkg::inc_hb_mode_t third_halfband_mode,
  output logic skip_third_halfband,
  output logic third_modulate,
  output logic [2:0] third_band_pos,
  output logic [31:0] active_tuning_word,
  output logic [15:0] carrier_phase,
  output logic [9:0] i_phase_adjust,
  output logic irq
);
  import inc_pkg::*;

  // ----------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------
  logic rst_meta_reg, rst_n, frame_meta_reg, frame_sync_reg;

  // reset asserts at once, releases two edges later
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // marker pin comes from the data interface, outside this domain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_meta_reg <= 1'b0;
      frame_sync_reg <= 1'b0;
    end else begin
      frame_meta_reg <= frame_marker;
      frame_sync_reg <= frame_meta_reg;
    end
  end

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // mode codes repeat a 3-bit position in both halves; top bit modulates.
  // a code whose halves differ is treated as position 0, unmodulated.
  function automatic logic [3:0] hb_decode(input inc_hb_mode_t m);
    logic ok;
    ok = (m[5:3] == m[2:0]);
    hb_decode = ok ? {m[5], m[5:3]} : 4'h0;
  endfunction : hb_decode

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  inc_byte_t hb2_ctl_reg;
  inc_byte_t hb3_ctl_reg;
  inc_byte_t tw_b0_reg, tw_b1_reg, tw_b2_reg, tw_b3_reg;
  inc_byte_t ph_lo_reg;
  inc_byte_t ph_hi_reg;
  inc_byte_t iph_lo_reg;
  logic [1:0] iph_hi_reg;
  logic [1:0] irq_mask_reg;
  logic wr_hb2, wr_hb3, wr_upd, wr_stat;
  logic [31:0] pending_tw;

  assign wr_hb2 = reg_wr && hit(reg_addr, `INC_ADDR_HB2_CTL);
  assign wr_hb3 = reg_wr && hit(reg_addr, `INC_ADDR_HB3_CTL);
  assign wr_upd = reg_wr && hit(reg_addr, `INC_ADDR_UPDATE);
  assign wr_stat = reg_wr && hit(reg_addr, `INC_ADDR_IRQ_STAT);
  // byte 0 is least significant
  assign pending_tw = {tw_b3_reg, tw_b2_reg, tw_b1_reg, tw_b0_reg};

  // halfband control; bit 7 unused and kept at zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb2_ctl_reg <= `INC_ZERO8;
      hb3_ctl_reg <= `INC_ZERO8;
    end else begin
      if (wr_hb2) begin
        hb2_ctl_reg <= {1'b0, reg_wdata[6:0]};
      end
      if (wr_hb3) begin
        hb3_ctl_reg <= {1'b0, reg_wdata[6:0]};
      end
    end
  end

  // staging bytes only; the oscillator sees them at a load
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tw_b0_reg <= `INC_ZERO8;
      tw_b1_reg <= `INC_ZERO8;
      tw_b2_reg <= `INC_ZERO8;
      tw_b3_reg <= `INC_ZERO8;
    end else if (reg_wr) begin
      if (hit(reg_addr, `INC_ADDR_TW_B0)) tw_b0_reg <= reg_wdata;
      if (hit(reg_addr, `INC_ADDR_TW_B1)) tw_b1_reg <= reg_wdata;
      if (hit(reg_addr, `INC_ADDR_TW_B2)) tw_b2_reg <= reg_wdata;
      if (hit(reg_addr, `INC_ADDR_TW_B3)) tw_b3_reg <= reg_wdata;
    end
  end

  // phase offset, I phase adjust and interrupt mask
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_lo_reg <= `INC_ZERO8;
      ph_hi_reg <= `INC_ZERO8;
      iph_lo_reg <= `INC_ZERO8;
      iph_hi_reg <= `INC_ZERO2;
      irq_mask_reg <= `INC_ZERO2;
    end else if (reg_wr) begin
      if (hit(reg_addr, `INC_ADDR_PH_LO)) ph_lo_reg <= reg_wdata;
      if (hit(reg_addr, `INC_ADDR_PH_HI)) ph_hi_reg <= reg_wdata;
      if (hit(reg_addr, `INC_ADDR_IPH_LO)) iph_lo_reg <= reg_wdata;
      if (hit(reg_addr, `INC_ADDR_IPH_HI)) iph_hi_reg <= reg_wdata[1:0];
      if (hit(reg_addr, `INC_ADDR_IRQ_MASK)) irq_mask_reg <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------
  // tuning word load handshake
  // ----------------------------------------
  logic load_req_reg;
  logic load_ack_reg;
  logic load_fire;
  logic [31:0] active_tw_reg;

  // edge is seen on the write itself, so no extra cycle of latency
  assign load_fire = wr_upd && reg_wdata[`INC_LOAD_REQ_BIT] && !load_req_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_req_reg <= 1'b0;
      load_ack_reg <= 1'b0;
      active_tw_reg <= `INC_ZERO32;
    end else begin
      if (wr_upd) begin
        load_req_reg <= reg_wdata[`INC_LOAD_REQ_BIT];
      end
      if (load_fire) begin
        active_tw_reg <= pending_tw;
        load_ack_reg <= 1'b1;
      end else if (wr_upd && !reg_wdata[`INC_LOAD_REQ_BIT]) begin
        load_ack_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // marker reset handshake
  // ----------------------------------------
  inc_mark_state_t mark_state_reg;
  logic mark_req_reg;
  logic mark_ack_reg;
  logic [2:0] mark_cnt_reg;
  logic ext_mark;
  logic osc_rst;
  logic mark_arm;

  // one event per long pulse: fires as the count reaches the threshold
  assign ext_mark = frame_sync_reg && (mark_cnt_reg == `INC_EXT_MARK_CYC - 3'h1);
  assign mark_arm = wr_upd && reg_wdata[`INC_MARK_REQ_BIT] && !mark_req_reg;
  assign osc_rst = ext_mark && (mark_state_reg == INC_MARK_ARMED);

  // saturating length counter of the synchronised marker
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_cnt_reg <= 3'h0;
    end else if (!frame_sync_reg) begin
      mark_cnt_reg <= 3'h0;
    end else if (mark_cnt_reg != `INC_EXT_MARK_CYC) begin
      mark_cnt_reg <= mark_cnt_reg + 3'h1;
    end
  end

  // a marker already past the threshold when armed does not count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_state_reg <= INC_MARK_IDLE;
    end else begin
      case (mark_state_reg)
        INC_MARK_IDLE: begin
          if (mark_arm) mark_state_reg <= INC_MARK_ARMED;
        end
        INC_MARK_ARMED: begin
          if (osc_rst) mark_state_reg <= INC_MARK_IDLE;
        end
        default: mark_state_reg <= INC_MARK_IDLE;
      endcase
    end
  end

  // request bit and acknowledge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_req_reg <= 1'b0;
      mark_ack_reg <= 1'b0;
    end else begin
      if (wr_upd) begin
        mark_req_reg <= reg_wdata[`INC_MARK_REQ_BIT];
      end
      if (osc_rst) begin
        mark_ack_reg <= 1'b1;
      end else if (wr_upd && !reg_wdata[`INC_MARK_REQ_BIT]) begin
        mark_ack_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // carrier oscillator phase
  // ----------------------------------------
  logic [31:0] phase_acc_reg;

  // signed offset maps onto the wrap: 2^16 steps span the whole circle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_acc_reg <= `INC_ZERO32;
    end else if (osc_rst) begin
      phase_acc_reg <= {ph_hi_reg, ph_lo_reg, `INC_ZERO16};
    end else begin
      phase_acc_reg <= phase_acc_reg + active_tw_reg;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [1:0] irq_stat_reg, irq_clr, irq_set;

  assign irq_clr = wr_stat ? reg_wdata[1:0] : `INC_ZERO2;
  assign irq_set = {osc_rst, load_fire};

  // set beats a clear written in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= `INC_ZERO2;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------
  // registered datapath controls
  // ----------------------------------------
  logic [3:0] hb2_dec, hb3_dec;

  assign hb2_dec = hb_decode(hb2_ctl_reg[`INC_MODE_MSB:`INC_MODE_LSB]);
  assign hb3_dec = hb_decode(hb3_ctl_reg[`INC_MODE_MSB:`INC_MODE_LSB]);

  // outputs lag the control bytes by one cycle to stay flop-driven
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      second_halfband_mode <= 6'h00;
      skip_second_halfband <= 1'b0;
      second_modulate <= 1'b0;
      second_band_pos <= 3'h0;
      third_halfband_mode <= 6'h00;
      skip_third_halfband <= 1'b0;
      third_modulate <= 1'b0;
      third_band_pos <= 3'h0;
      i_phase_adjust <= 10'h000;
    end else begin
      second_halfband_mode <= hb2_ctl_reg[`INC_MODE_MSB:`INC_MODE_LSB];
      skip_second_halfband <= hb2_ctl_reg[`INC_SKIP_BIT];
      second_modulate <= hb2_dec[3];
      second_band_pos <= hb2_dec[2:0];
      third_halfband_mode <= hb3_ctl_reg[`INC_MODE_MSB:`INC_MODE_LSB];
      skip_third_halfband <= hb3_ctl_reg[`INC_SKIP_BIT];
      third_modulate <= hb3_dec[3];
      third_band_pos <= hb3_dec[2:0];
      i_phase_adjust <= {iph_hi_reg, iph_lo_reg};
    end
  end

  assign active_tuning_word = active_tw_reg;
  assign carrier_phase = phase_acc_reg[31:16];

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // unmapped addresses read zero; data stands one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `INC_ZERO8;
    end else if (reg_rd) begin
      case (reg_addr)
        `INC_ADDR_HB2_CTL: reg_rdata <= hb2_ctl_reg;
        `INC_ADDR_HB3_CTL: reg_rdata <= hb3_ctl_reg;
        `INC_ADDR_PART_ID: reg_rdata <= `INC_PART_ID;
        `INC_ADDR_TW_B0: reg_rdata <= tw_b0_reg;
        `INC_ADDR_TW_B1: reg_rdata <= tw_b1_reg;
        `INC_ADDR_TW_B2: reg_rdata <= tw_b2_reg;
        `INC_ADDR_TW_B3: reg_rdata <= tw_b3_reg;
        `INC_ADDR_PH_LO: reg_rdata <= ph_lo_reg;
        `INC_ADDR_PH_HI: reg_rdata <= ph_hi_reg;
        `INC_ADDR_UPDATE: begin
          reg_rdata <= {2'h0, mark_ack_reg, mark_req_reg, 2'h0,
                        load_ack_reg, load_req_reg};
        end
        `INC_ADDR_IPH_LO: reg_rdata <= iph_lo_reg;
        `INC_ADDR_IPH_HI: reg_rdata <= {6'h00, iph_hi_reg};
        `INC_ADDR_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_reg};
        `INC_ADDR_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_reg};
        default: reg_rdata <= `INC_ZERO8;
      endcase
    end else begin
      reg_rdata <= `INC_ZERO8;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_LOAD_WORD: assert property (
    $rose(load_req_reg) |-> active_tw_reg == $past(pending_tw))
    else $error("tuning word not loaded on request edge");
  AST_WORD_HOLD: assert property (
    !$rose(load_req_reg) |-> $stable(active_tw_reg))
    else $error("active tuning word moved without request edge");
  AST_LOAD_ACK: assert property (
    $rose(load_req_reg) |-> load_ack_reg ##1 (load_ack_reg || !load_req_reg))
    else $error("load acknowledge missing");
  AST_ACK_CLEAR: assert property (
    ($fell(load_req_reg) |-> !load_ack_reg) and ($fell(mark_req_reg) |-> !mark_ack_reg))
    else $error("acknowledge not cleared with request");
  AST_PHASE_INIT: assert property (
    osc_rst |=> phase_acc_reg == {$past(ph_hi_reg), $past(ph_lo_reg), 16'h0000})
    else $error("oscillator phase not set to offset");
  AST_MARK_ACK: assert property (
    osc_rst |=> mark_ack_reg && mark_state_reg == INC_MARK_IDLE)
    else $error("marker acknowledge missing");
  // second synced high cycle after a low one, seen apart from the length counter
  AST_MARK_ARMED: assert property (
    mark_state_reg == INC_MARK_ARMED && frame_sync_reg && $past(frame_sync_reg)
    && !$past(frame_sync_reg, 2) |-> osc_rst)
    else $error("armed marker did not reset oscillator");
  AST_SKIP: assert property (
    skip_second_halfband == $past(hb2_ctl_reg[0])
    && skip_third_halfband == $past(hb3_ctl_reg[0]))
    else $error("bypass output disagrees with control bit");
  AST_HB3_MOD: assert property (
    third_modulate == $past(hb3_ctl_reg[6] && hb3_ctl_reg[6:4] == hb3_ctl_reg[3:1]))
    else $error("third stage modulation decode wrong");
  AST_PART_ID: assert property (
    reg_rd && reg_addr == `INC_ADDR_PART_ID |=> reg_rdata == `INC_PART_ID)
    else $error("identity read wrong");
  AST_IPHASE: assert property (
    i_phase_adjust == $past({iph_hi_reg, iph_lo_reg}))
    else $error("I phase adjust output wrong");
  AST_IRQ: assert property (
    irq == $past(|(irq_stat_reg & irq_mask_reg)))
    else $error("interrupt output wrong");
endmodule : inc_regs

// *** test/inc_regs_test.sv ***
// self-checking bench for the halfband, carrier oscillator and I phase register bank
// assumes: inc_pkg and inc_cfg.svh compiled first, single 250 MHz sys_clk domain
`timescale 1ns/1ns
`include "inc_cfg.svh"

module inc_regs_test;
  import inc_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic frame_marker = 1'b0;
  logic [7:0] reg_rdata;
  inc_hb_mode_t second_halfband_mode;
  inc_hb_mode_t third_halfband_mode;
  logic skip_second_halfband;
  logic skip_third_halfband;
  logic second_modulate;
  logic third_modulate;
  logic [2:0] second_band_pos;
  logic [2:0] third_band_pos;
  logic [31:0] active_tuning_word;
  logic [15:0] carrier_phase;
  logic [9:0] i_phase_adjust;
  logic irq;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [5:0] code;
  // rows: address, reset value, value written, value read back
  localparam int NR = 15;
  localparam logic [31:0] ROWS [NR] = '{
    {8'h1D, 8'h00, 8'hFF, 8'h7F}, {8'h1E, 8'h00, 8'hFF, 8'h7F},
    {8'h1F, `INC_PART_ID, 8'h00, `INC_PART_ID},
    {8'h30, 8'h00, 8'h11, 8'h11}, {8'h31, 8'h00, 8'h22, 8'h22},
    {8'h32, 8'h00, 8'h33, 8'h33}, {8'h33, 8'h00, 8'h44, 8'h44},
    {8'h34, 8'h00, 8'hCD, 8'hCD}, {8'h35, 8'h00, 8'hAB, 8'hAB},
    {8'h38, 8'h00, 8'h5A, 8'h5A}, {8'h39, 8'h00, 8'h02, 8'h02},
    {8'h21, 8'h00, 8'h00, 8'h00}, {8'h36, 8'h00, 8'h00, 8'h00},
    {8'h37, 8'h00, 8'h55, 8'h00}, {8'h3A, 8'h00, 8'h66, 8'h00}};

  always #2 sys_clk = ~sys_clk;

  inc_regs uut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_marker(frame_marker),
    .second_halfband_mode(second_halfband_mode), .skip_second_halfband(skip_second_halfband),
    .second_modulate(second_modulate), .second_band_pos(second_band_pos),
    .third_halfband_mode(third_halfband_mode), .skip_third_halfband(skip_third_halfband),
    .third_modulate(third_modulate), .third_band_pos(third_band_pos),
    .active_tuning_word(active_tuning_word), .carrier_phase(carrier_phase),
    .i_phase_adjust(i_phase_adjust), .irq(irq));

  // ---------------------------------------------------------------
  // bus, marker and compare tasks
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp($sformatf("reg %h", a), {24'h0, exp}, {24'h0, d});
  endtask : rd_cmp

  // marker pin held high for n cycles, then low again
  task automatic mark(input int n);
    @(posedge sys_clk);
    frame_marker <= 1'b1;
    tick(n);
    frame_marker <= 1'b0;
    tick(8);
  endtask : mark

  task automatic final_report;
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    // a real falling edge at time zero resets the bank before the first clock
    nrst <= 1'b0;
    tick(8);
    nrst <= 1'b1;
    tick(3);
    // reset values, then write and read back every row
    for (int i = 0; i < NR; i++) begin
      rd_cmp(ROWS[i][31:24], ROWS[i][23:16]);
    end
    for (int i = 0; i < NR; i++) begin
      wr(ROWS[i][31:24], ROWS[i][15:8]);
      rd_cmp(ROWS[i][31:24], ROWS[i][7:0]);
    end
    tick(2);
    cmp("skip2", 1, skip_second_halfband);
    cmp("skip3", 1, skip_third_halfband);
    cmp("iphase", 32'h25A, i_phase_adjust);
    cmp("word held", 0, active_tuning_word);
    // every valid code of both stages, skip bit toggled alongside
    for (int p = 0; p < 8; p++) begin
      code = {p[2:0], p[2:0]};
      wr(`INC_ADDR_HB2_CTL, {1'b0, code, p[0]});
      wr(`INC_ADDR_HB3_CTL, {1'b0, code, ~p[0]});
      tick(2);
      cmp("mode2", code, second_halfband_mode);
      cmp("mod2", p[2], second_modulate);
      cmp("pos2", p[2:0], second_band_pos);
      cmp("skip2", p[0], skip_second_halfband);
      cmp("mode3", code, third_halfband_mode);
      cmp("mod3", p[2], third_modulate);
      cmp("pos3", p[2:0], third_band_pos);
      cmp("skip3", !p[0], skip_third_halfband);
    end
    // a code with unequal halves counts as unmodulated position 0
    wr(`INC_ADDR_HB3_CTL, 8'h0E);
    tick(2);
    cmp("mod3 odd", 0, third_modulate);
    cmp("pos3 odd", 0, third_band_pos);
    // tuning word load handshake
    wr(`INC_ADDR_UPDATE, 8'h01);
    tick(1);
    cmp("word", 32'h44332211, active_tuning_word);
    rd_cmp(`INC_ADDR_UPDATE, 8'h03);
    wr(`INC_ADDR_TW_B0, 8'h99);
    wr(`INC_ADDR_UPDATE, 8'h01);
    tick(2);
    cmp("word no edge", 32'h44332211, active_tuning_word);
    rd_cmp(`INC_ADDR_IRQ_STAT, 8'h01);
    cmp("irq masked", 0, irq);
    wr(`INC_ADDR_IRQ_MASK, 8'h01);
    tick(2);
    cmp("irq", 1, irq);
    wr(`INC_ADDR_IRQ_STAT, 8'h01);
    tick(2);
    cmp("irq clr", 0, irq);
    rd_cmp(`INC_ADDR_IRQ_STAT, 8'h00);
    wr(`INC_ADDR_UPDATE, 8'h00);
    rd_cmp(`INC_ADDR_UPDATE, 8'h00);
    wr(`INC_ADDR_UPDATE, 8'h01);
    tick(1);
    cmp("word 2", 32'h44332299, active_tuning_word);
    // zero word so the phase holds still after the marker reset
    for (int b = 0; b < 4; b++) begin
      wr(8'h30 + b[7:0], 8'h00);
    end
    wr(`INC_ADDR_UPDATE, 8'h00);
    wr(`INC_ADDR_UPDATE, 8'h01);
    wr(`INC_ADDR_UPDATE, 8'h00);
    tick(1);
    cmp("word 0", 0, active_tuning_word);
    // marker while unarmed, then a short one while armed: both ignored
    mark(4);
    rd_cmp(`INC_ADDR_UPDATE, 8'h00);
    wr(`INC_ADDR_UPDATE, 8'h10);
    mark(1);
    rd_cmp(`INC_ADDR_UPDATE, 8'h10);
    wr(`INC_ADDR_IRQ_MASK, 8'h02);
    mark(4);
    rd_cmp(`INC_ADDR_UPDATE, 8'h30);
    cmp("phase", 16'hABCD, carrier_phase);
    cmp("irq mark", 1, irq);
    // load status from the later loads is still pending beside the marker bit
    rd_cmp(`INC_ADDR_IRQ_STAT, 8'h03);
    wr(`INC_ADDR_UPDATE, 8'h00);
    rd_cmp(`INC_ADDR_UPDATE, 8'h00);
    // reset in mid-run clears outputs and registers
    @(posedge sys_clk);
    nrst <= 1'b0;
    tick(2);
    cmp("rst outs", 0, {i_phase_adjust, third_halfband_mode, skip_third_halfband, irq});
    cmp("rst phase", 0, carrier_phase);
    nrst <= 1'b1;
    tick(3);
    rd_cmp(`INC_ADDR_IPH_LO, 8'h00);
    rd_cmp(`INC_ADDR_PH_HI, 8'h00);
    final_report();
  end
endmodule : inc_regs_test
